// ---- gee_params.svh ----
// register offsets, field positions and reset values for the edge event block
`ifndef GEE_PARAMS_SVH
`define GEE_PARAMS_SVH
`define GEE_ADDR_MASK 8'h05
`define GEE_ADDR_SENSE_HI 8'h06
`define GEE_ADDR_SENSE_LO 8'h07
`define GEE_ADDR_SOURCE 8'h08
`define GEE_ADDR_EVENT 8'h09
`define GEE_ADDR_MODE 8'h10
`define GEE_RST_MASK 8'hFF
`define GEE_RST_SENSE 8'h00
`define GEE_RST_FLAGS 8'h00
`define GEE_RST_MODE 8'h00
`define GEE_MODE_UP_HI 5
`define GEE_MODE_UP_LO 4
`define GEE_MODE_LO_HI 1
`define GEE_MODE_LO_LO 0
`define GEE_LINES 8
`endif

// ---- gee_pkg.sv ----
// types for the edge event block
package gee_pkg;
  typedef enum logic [1:0] {
    GEE_SENSE_NONE,
    GEE_SENSE_RISE,
    GEE_SENSE_FALL,
    GEE_SENSE_BOTH
  } gee_sense_t;
  typedef enum logic [1:0] {
    GEE_LF_OFF,
    GEE_LF_2TO1,
    GEE_LF_3TO1,
    GEE_LF_3TO2
  } gee_lf_mode_t;
endpackage

// ---- gee_edge_if.sv ----
// carries per-line edge strobes from the detector to the register core
interface gee_edge_if;
  logic [7:0] edge_hit;
  modport det (output edge_hit);
  modport core (input edge_hit);
endinterface

// ---- gee_edge_detect.sv ----
// synchroniser and per-line edge detector
`include "gee_params.svh"
module gee_edge_detect
  import gee_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [7:0] pins_in,
  input wire logic [15:0] sense_in,
  gee_edge_if.det edges
);
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] prev_q;

  // two stages before use; first stage feeds only the second
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      prev_q <= 8'h00;
    end else begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  function automatic logic hit(input logic [1:0] s, input logic now, input logic was);
    unique case (gee_sense_t'(s))
      GEE_SENSE_NONE: hit = 1'b0;
      GEE_SENSE_RISE: hit = now & ~was;
      GEE_SENSE_FALL: hit = ~now & was;
      GEE_SENSE_BOTH: hit = now ^ was;
    endcase
  endfunction

  genvar i;
  generate
    for (i = 0; i < `GEE_LINES; i++) begin : g_line
      // line n uses bits 2n+1:2n of the merged sense word
      assign edges.edge_hit[i] = hit(sense_in[2*i+1 -: 2], sync2_q[i], prev_q[i]);
    end
  endgenerate

  chk_rise_detect: assert property (@(posedge clock_in) disable iff (reset_in)
    (sense_in[1:0] == 2'h1 && sync2_q[0] && !prev_q[0]) |-> edges.edge_hit[0])
    else $error("rising edge on line 0 missed");
  chk_none_quiet: assert property (@(posedge clock_in) disable iff (reset_in)
    (sense_in[1:0] == 2'h0) |-> !edges.edge_hit[0])
    else $error("edge reported with sensitivity off");
endmodule

// ---- gee_core.sv ----
// edge event latching, interrupt masking and logic function mode for eight lines
`include "gee_params.svh"
// Contract
// - mask bit 0 lets a line interrupt; mask bit 1 blocks it.
// - sense code 00 none, 01 rising, 10 falling, 11 both edges.
// - upper sense register holds lines 7-4, lower holds 3-0, two bits each.
// - configured edge on unmasked line sets its interrupt source flag.
// - interrupt output releases once all source bits are clear.
// - event bit sets on configured edge regardless of mask.
// - upper mode 00 leaves lines 7-4 as plain I/O, except line 4 when the lower mode is 3-to-2.
// - lower 3-to-1 mode drives line 3 from the decode of lines 2-0.
// - changing a line's sensitivity clears its pending event and source bits.
// - direction 1 is input and may interrupt; 0 is output.
module gee_core
  import gee_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [7:0] pins_in,
  input wire logic [7:0] direction_bits_in,
  input wire logic [7:0] out_data_in,
  input wire logic [1:0] table_lo_in,
  input wire logic [1:0] table_hi_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic [7:0] io_out_out,
  output logic irq_out_n_out,
  output logic irq_oe_out
);
  logic [7:0] interrupt_mask_q;
  logic [7:0] edge_sense_upper_q;
  logic [7:0] edge_sense_lower_q;
  logic [7:0] interrupt_source_flags_q;
  logic [7:0] event_flags_q;
  logic [7:0] logic_function_mode_q;
  logic [7:0] sense_chg_d;
  logic [7:0] clr_d;
  logic [7:0] rdata_d;
  logic [7:0] io_d;
  logic [7:0] src_set;
  logic [7:0] evt_set;

  gee_edge_if edges ();

  gee_edge_detect u_det (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .pins_in(pins_in),
    .sense_in({edge_sense_upper_q, edge_sense_lower_q}),
    .edges(edges)
  );

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
    is_addr = (a == ref_a);
  endfunction

  // configuration writes
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      interrupt_mask_q <= `GEE_RST_MASK;
      edge_sense_upper_q <= `GEE_RST_SENSE;
      edge_sense_lower_q <= `GEE_RST_SENSE;
      logic_function_mode_q <= `GEE_RST_MODE;
    end else if (wr_en_in) begin
      if (is_addr(addr_in, `GEE_ADDR_MASK)) begin
        interrupt_mask_q <= wdata_in;
      end
      if (is_addr(addr_in, `GEE_ADDR_SENSE_HI)) begin
        edge_sense_upper_q <= wdata_in;
      end
      if (is_addr(addr_in, `GEE_ADDR_SENSE_LO)) begin
        edge_sense_lower_q <= wdata_in;
      end
      if (is_addr(addr_in, `GEE_ADDR_MODE)) begin
        // reserved bits are stored as written; host keeps them zero
        logic_function_mode_q <= wdata_in;
      end
    end
  end

  // per-line clear: write-1 on either flag register or a sense change
  always_comb begin
    sense_chg_d = 8'h00;
    clr_d = 8'h00;
    if (wr_en_in) begin
      for (int i = 0; i < 4; i++) begin
        if (is_addr(addr_in, `GEE_ADDR_SENSE_LO) &&
            wdata_in[2*i +: 2] != edge_sense_lower_q[2*i +: 2]) begin
          sense_chg_d[i] = 1'b1;
        end
        if (is_addr(addr_in, `GEE_ADDR_SENSE_HI) &&
            wdata_in[2*i +: 2] != edge_sense_upper_q[2*i +: 2]) begin
          sense_chg_d[i+4] = 1'b1;
        end
      end
      if (is_addr(addr_in, `GEE_ADDR_SOURCE) || is_addr(addr_in, `GEE_ADDR_EVENT)) begin
        clr_d = wdata_in;
      end
    end
    clr_d = clr_d | sense_chg_d;
  end

  assign evt_set = edges.edge_hit;
  // only unmasked input lines interrupt
  assign src_set = edges.edge_hit & ~interrupt_mask_q & direction_bits_in;

  // a new edge wins over a clear in the same cycle, except in a cycle that writes a change to that line's sense
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      event_flags_q <= `GEE_RST_FLAGS;
      interrupt_source_flags_q <= `GEE_RST_FLAGS;
    end else begin
      event_flags_q <= (event_flags_q & ~clr_d) | (evt_set & ~sense_chg_d);
      interrupt_source_flags_q <= (interrupt_source_flags_q & ~clr_d) |
                                  (src_set & ~sense_chg_d);
    end
  end

  // open drain: drive low while any source bit pending, one cycle behind the flags
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      irq_out_n_out <= 1'b1;
      irq_oe_out <= 1'b0;
    end else begin
      irq_out_n_out <= ~(|interrupt_source_flags_q);
      irq_oe_out <= |interrupt_source_flags_q;
    end
  end

  // read mux
  always_comb begin
    rdata_d = 8'h00;
    unique case (addr_in)
      `GEE_ADDR_MASK: rdata_d = interrupt_mask_q;
      `GEE_ADDR_SENSE_HI: rdata_d = edge_sense_upper_q;
      `GEE_ADDR_SENSE_LO: rdata_d = edge_sense_lower_q;
      `GEE_ADDR_SOURCE: rdata_d = interrupt_source_flags_q;
      `GEE_ADDR_EVENT: rdata_d = event_flags_q;
      `GEE_ADDR_MODE: rdata_d = logic_function_mode_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
    end else if (rd_en_in) begin
      rdata_out <= rdata_d;
    end
  end

  // output data with logic-function overrides from the external truth table
  always_comb begin
    gee_lf_mode_t up;
    gee_lf_mode_t lo;
    up = gee_lf_mode_t'(logic_function_mode_q[`GEE_MODE_UP_HI:`GEE_MODE_UP_LO]);
    lo = gee_lf_mode_t'(logic_function_mode_q[`GEE_MODE_LO_HI:`GEE_MODE_LO_LO]);
    io_d = out_data_in;
    unique case (lo)
      GEE_LF_OFF: io_d[3:0] = out_data_in[3:0];
      GEE_LF_2TO1: io_d[2] = table_lo_in[0];
      GEE_LF_3TO1: io_d[3] = table_lo_in[0];
      GEE_LF_3TO2: io_d[4:3] = table_lo_in;
    endcase
    unique case (up)
      GEE_LF_OFF: io_d[7:4] = io_d[7:4];
      GEE_LF_2TO1: io_d[6] = table_hi_in[0];
      GEE_LF_3TO1: io_d[7] = table_hi_in[0];
      GEE_LF_3TO2: io_d[7:4] = io_d[7:4];
    endcase
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      io_out_out <= 8'h00;
    end else begin
      io_out_out <= io_d;
    end
  end

  chk_mask_blocks: assert property (@(posedge clock_in) disable iff (reset_in)
    (edges.edge_hit[0] && interrupt_mask_q[0] && !interrupt_source_flags_q[0] && !clr_d[0])
      |=> !interrupt_source_flags_q[0])
    else $error("masked line raised a source flag");
  chk_src_sets: assert property (@(posedge clock_in) disable iff (reset_in)
    (src_set[0] && !sense_chg_d[0]) |=> interrupt_source_flags_q[0])
    else $error("unmasked edge did not set source flag");
  chk_evt_sets: assert property (@(posedge clock_in) disable iff (reset_in)
    (evt_set[5] && !sense_chg_d[5]) |=> event_flags_q[5])
    else $error("edge did not set event flag");
  chk_w1c_both: assert property (@(posedge clock_in) disable iff (reset_in)
    (wr_en_in && addr_in == `GEE_ADDR_EVENT && wdata_in[2] && !evt_set[2])
      |=> !interrupt_source_flags_q[2] && !event_flags_q[2])
    else $error("write one did not clear both flags");
  chk_irq_level: assert property (@(posedge clock_in) disable iff (reset_in)
    |interrupt_source_flags_q |=> !irq_out_n_out && irq_oe_out)
    else $error("interrupt not asserted with source pending");
  chk_irq_release: assert property (@(posedge clock_in) disable iff (reset_in)
    (interrupt_source_flags_q == 8'h00) |=> irq_out_n_out && !irq_oe_out)
    else $error("interrupt held with no source pending");
  chk_sense_clear: assert property (@(posedge clock_in) disable iff (reset_in)
    sense_chg_d[1] |=> !event_flags_q[1] && !interrupt_source_flags_q[1])
    else $error("sense change left pending flags");
  chk_output_line: assert property (@(posedge clock_in) disable iff (reset_in)
    (!direction_bits_in[3] && !interrupt_source_flags_q[3])
      |=> !interrupt_source_flags_q[3])
    else $error("output line produced interrupt");
  chk_lf_drive: assert property (@(posedge clock_in) disable iff (reset_in)
    (logic_function_mode_q[1:0] == 2'h2) |=> io_out_out[3] == $past(table_lo_in[0]))
    else $error("line 3 not driven by decode");
  chk_lf_off: assert property (@(posedge clock_in) disable iff (reset_in)
    // lower 3-to-2 mode takes line 4, so leave that combination out
    (logic_function_mode_q[5:4] == 2'h0 && logic_function_mode_q[1:0] != 2'h3)
      |=> io_out_out[7:4] == $past(out_data_in[7:4]))
    else $error("upper lines not plain I/O");

  cov_irq_raise: cover property (@(posedge clock_in) disable iff (reset_in)
    irq_out_n_out ##1 !irq_out_n_out);
  cov_irq_clear: cover property (@(posedge clock_in) disable iff (reset_in)
    !irq_out_n_out ##1 irq_out_n_out);
  cov_masked_event: cover property (@(posedge clock_in) disable iff (reset_in)
    evt_set[0] && interrupt_mask_q[0]);
endmodule

// ---- gee_host_model.sv ----
// host controller model: register strobes and the pulled-up interrupt wire
module gee_host_model (
  input wire logic clock_in,
  input wire logic [7:0] rdata_in,
  input wire logic irq_oe_in,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic irq_line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // only the device pulls the wire low, the pull-up does the rest
  assign irq_line_out = irq_oe_in ? 1'b0 : 1'b1;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_out <= a;
    wdata_out <= (a == 8'h10) ? (d & 8'h33) : d;
    wr_en_out <= 1'b1;
    @(posedge clock_in);
    wr_en_out <= 1'b0;
    // stale bus values must not look like a repeat
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    addr_out <= a;
    rd_en_out <= 1'b1;
    @(posedge clock_in);
    rd_en_out <= 1'b0;
    @(posedge clock_in);
    d = rdata_in;
  endtask
endmodule

// ---- gpio_edge_event_logic_test.sv ----
// self-checking bench for the edge event block
`include "gee_params.svh"
module gpio_edge_event_logic_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] pins, dir, out_data, rdata, io_out, addr, wdata, mask, ev, src, r, w;
  logic [1:0] tlo, thi;
  logic [1:0] s [8];
  logic wr_en, rd_en, irq_n, irq_oe, irq_line;
  int errors = 0;
  int check_count = 0;
  always #5 clock_in = ~clock_in;
  gee_core DUT (.clock_in(clock_in), .reset_in(reset_in), .pins_in(pins),
    .direction_bits_in(dir), .out_data_in(out_data), .table_lo_in(tlo), .table_hi_in(thi),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata),
    .rdata_out(rdata), .io_out_out(io_out), .irq_out_n_out(irq_n), .irq_oe_out(irq_oe));
  gee_host_model host (.clock_in(clock_in), .rdata_in(rdata), .irq_oe_in(irq_oe),
    .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata),
    .irq_line_out(irq_line));
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, r);
    chk(r, exp);
  endtask
  task automatic chk_flags;
    chk_reg(`GEE_ADDR_SOURCE, src);
    chk_reg(`GEE_ADDR_EVENT, ev);
    chk({7'h00, irq_line}, {7'h00, src == 8'h00});
    chk({7'h00, irq_n}, {7'h00, src == 8'h00});
  endtask
  task automatic pin(input int i, input logic v);
    logic old;
    logic hit;
    old = pins[i];
    @(posedge clock_in);
    pins[i] <= v;
    hit = (s[i][0] && !old && v) || (s[i][1] && old && !v);
    if (hit) ev[i] = 1'b1;
    if (hit && !mask[i] && dir[i]) src[i] = 1'b1;
    // two sync flops plus detect and flag stages
    repeat (6) @(posedge clock_in);
  endtask
  task automatic set_sense(input int p);
    for (int i = 0; i < 8; i++) begin
      if (s[i] != 2'((i + p) % 4)) begin
        ev[i] = 1'b0;
        src[i] = 1'b0;
      end
      s[i] = 2'((i + p) % 4);
    end
    host.wr(`GEE_ADDR_SENSE_HI, {s[7], s[6], s[5], s[4]});
    host.wr(`GEE_ADDR_SENSE_LO, {s[3], s[2], s[1], s[0]});
  endtask
  initial begin
    #200_000;
    errors++;
    $display("test watchdog expired");
    final_report();
  end
  initial begin
    logic [7:0] ra [7] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h10, 8'h3F};
    logic [7:0] re [7] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    void'($urandom(19598));
    {pins, dir, out_data, tlo, thi} = {8'h00, 8'hFF, 8'h00, 2'b00, 2'b00};
    {mask, ev, src} = {8'hFF, 8'h00, 8'h00};
    foreach (s[i]) s[i] = 2'b00;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    foreach (ra[k]) chk_reg(ra[k], re[k]);
    chk_flags();
    $display("test reset_values done");
    for (int p = 0; p < 4; p++) begin
      mask = 8'($urandom);
      dir <= 8'($urandom);
      host.wr(`GEE_ADDR_MASK, mask);
      set_sense(p);
      chk_flags();
      for (int i = 0; i < 8; i++) begin
        pin(i, 1'b1);
        pin(i, 1'b0);
      end
      chk_flags();
      w = 8'($urandom);
      host.wr(`GEE_ADDR_EVENT, w);
      ev &= ~w;
      src &= ~w;
      chk_flags();
      $display("test edge_pass %0d done", p);
    end
    host.wr(`GEE_ADDR_SOURCE, 8'hFF);
    {ev, src} = 16'h0000;
    chk_flags();
    for (int k = 0; k < 4; k++) begin
      out_data <= 8'($urandom);
      tlo <= 2'($urandom);
      thi <= 2'($urandom);
      host.wr(`GEE_ADDR_MODE, 8'h00);
      repeat (3) @(posedge clock_in);
      chk(io_out, out_data);
      host.wr(`GEE_ADDR_MODE, 8'h02);
      repeat (3) @(posedge clock_in);
      chk(io_out, {out_data[7:4], tlo[0], out_data[2:0]});
      host.wr(`GEE_ADDR_MODE, 8'h01);
      repeat (3) @(posedge clock_in);
      chk(io_out, {out_data[7:3], tlo[0], out_data[1:0]});
      host.wr(`GEE_ADDR_MODE, 8'h12);
      repeat (3) @(posedge clock_in);
      chk(io_out, {out_data[7], thi[0], out_data[5:4], tlo[0], out_data[2:0]});
      host.wr(`GEE_ADDR_MODE, 8'h23);
      repeat (3) @(posedge clock_in);
      chk(io_out, {thi[0], out_data[6:5], tlo, out_data[2:0]});
    end
    $display("test logic_mode done");
    final_report();
  end
endmodule
